// ### rtl/ahts_defs.svh
// Offsets, field positions, reset values and timing figures of the sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef AHTS_DEFS_SVH
`define AHTS_DEFS_SVH
// Timing
`define AHTS_CLK_MHZ 250
`define AHTS_NS_PER_US 1000
`define AHTS_CONV_NS 54000
`define AHTS_SAMPLE_STEPS 4
`define AHTS_RES_BITS 12
`define AHTS_RES_LOW_12 4'h0
`define AHTS_RES_LOW_8 4'h4
`define AHTS_SAR_MSB 12'h800
// Register word offsets
`define AHTS_A_PERIPH 3'h0
`define AHTS_A_MODE0 3'h1
`define AHTS_A_MODE1 3'h2
`define AHTS_A_MODE2 3'h3
`define AHTS_A_CHAN 3'h4
`define AHTS_A_RESULT 3'h5
`define AHTS_A_STAT 3'h6
`define AHTS_A_MASK 3'h7
// Field positions
`define AHTS_PE_GATE 0
`define AHTS_M0_EN 0
`define AHTS_M0_ARM 1
`define AHTS_M0_CSM 2
`define AHTS_M0_BUSY 3
`define AHTS_M1_SRC 1:0
`define AHTS_M1_ONESHOT 2
`define AHTS_M1_TMODE 4:3
`define AHTS_M2_RES 0
`define AHTS_M2_NREF 1
`define AHTS_M2_PREF 3:2
`define AHTS_CH_NUM 4:0
`define AHTS_CH_ISS 7
`define AHTS_IRQ_DONE 0
`define AHTS_IRQ_OVR 1
// Reset values and codes
`define AHTS_RST_CHAN 5'h00
`define AHTS_RST_2B 2'h0
`define AHTS_RST_RES 12'h000
`define AHTS_RST_DATA 16'h0000
`define AHTS_TM_HW_NOWAIT 2'h2
`define AHTS_SRC_TIMER1 2'h0
`endif

// ### rtl/ahts_pkg.sv
// Types shared by the conversion sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package ahts_pkg;
  typedef enum logic [2:0] {
    ST_STOP = 3'b000,
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_STORE = 3'b011,
    ST_DONE = 3'b100
  } ahts_state_t;
endpackage

// ### rtl/ahts_sequencer.sv
// Timer-triggered successive-approximation converter control with registers.
// Assumes triggers are one-cycle pulses on ref_clk; comparator is asynchronous.
`timescale 1ns/100ps
`include "ahts_defs.svh"
module ahts_sequencer #(
  parameter int CONV_CYCLES = `AHTS_CONV_NS * `AHTS_CLK_MHZ / `AHTS_NS_PER_US,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Trigger sources
  input wire logic timer_ch1_irq,
  input wire logic [2:0] ext_trig,
  // Analog front end
  input wire logic comp_in,
  output logic [11:0] dac_code,
  output logic sample_en,
  output logic [4:0] amux_sel,
  output logic amux_internal,
  output logic [1:0] pos_ref_out,
  output logic neg_ref_out,
  output logic busy,
  // Interrupts
  output logic conv_done_irq,
  output logic irq
);
  localparam int STEPS = `AHTS_SAMPLE_STEPS + `AHTS_RES_BITS;
  localparam int STEP_CYC = CONV_CYCLES / STEPS;

  // Register address match
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    return a == off;
  endfunction

  // Trigger source pick
  function automatic logic trig_pick(input logic [1:0] s, input logic [3:0] v);
    return v[s];
  endfunction

  ahts_pkg::ahts_state_t state, next_state;
  logic conv_clock_gate;
  logic conv_enable, conv_start_arm, chan_sel_mode;
  logic [1:0] trig_src;
  logic [1:0] trig_mode;
  logic oneshot_sel;
  logic resolution_sel, neg_ref_sel;
  logic [1:0] pos_ref;
  logic internal_src_sel;
  logic [4:0] input_channel_reg;
  logic [11:0] conv_result_reg;
  logic [1:0] irq_stat, irq_mask, irq_evt, next_stat;
  logic act_res;
  logic [CNT_W-1:0] tcnt, scnt;
  logic [3:0] step;
  logic tick;
  logic comp_s1, comp_s2, comp_s3, comp_q;
  logic wr_ok, rd_ok, hw_mode, trig_sel, trig_hit, sw_go, start_go, load_cfg;
  logic [3:0] bitpos, lowbit;

  // Access qualified by the clock gate
  assign wr_ok = reg_wr && conv_clock_gate;
  assign rd_ok = reg_rd && conv_clock_gate;
  assign hw_mode = trig_mode[1];
  assign trig_sel = trig_pick(trig_src, {ext_trig, timer_ch1_irq});
  assign trig_hit = (state == ahts_pkg::ST_IDLE) && conv_start_arm && hw_mode && trig_sel;
  assign sw_go = (state == ahts_pkg::ST_IDLE) && !hw_mode && wr_ok &&
                 hit(reg_addr, `AHTS_A_MODE0) && reg_wdata[`AHTS_M0_ARM] &&
                 reg_wdata[`AHTS_M0_EN];
  assign start_go = trig_hit || sw_go;
  assign load_cfg = ((state == ahts_pkg::ST_STOP) && conv_enable) || start_go;
  assign tick = (state == ahts_pkg::ST_CONV) && (scnt == CNT_W'(STEP_CYC - 1));
  assign lowbit = act_res ? `AHTS_RES_LOW_8 : `AHTS_RES_LOW_12;
  assign bitpos = 4'(`AHTS_RES_BITS - 1 + `AHTS_SAMPLE_STEPS) - step;

  // Peripheral clock gate, always reachable
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      conv_clock_gate <= 1'b0;
    else if (reg_wr && hit(reg_addr, `AHTS_A_PERIPH))
      conv_clock_gate <= reg_wdata[`AHTS_PE_GATE];
  end

  // Mode register 0: enable, channel mode
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      conv_enable <= 1'b0;
      chan_sel_mode <= 1'b0;
    end
    else if (wr_ok && hit(reg_addr, `AHTS_A_MODE0))
    begin
      conv_enable <= reg_wdata[`AHTS_M0_EN];
      chan_sel_mode <= reg_wdata[`AHTS_M0_CSM];
    end
  end

  // Arm bit: held through hardware one-shot, dropped by software one-shot
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      conv_start_arm <= 1'b0;
    else if (wr_ok && hit(reg_addr, `AHTS_A_MODE0))
      conv_start_arm <= reg_wdata[`AHTS_M0_ARM] && reg_wdata[`AHTS_M0_EN];
    else if (!conv_enable || !conv_clock_gate)
      conv_start_arm <= 1'b0;
    else if ((state == ahts_pkg::ST_DONE) && !hw_mode && oneshot_sel)
      conv_start_arm <= 1'b0;
  end

  // Mode registers 1 and 2, channel register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trig_src <= `AHTS_RST_2B;
      trig_mode <= `AHTS_RST_2B;
      oneshot_sel <= 1'b0;
      resolution_sel <= 1'b0;
      neg_ref_sel <= 1'b0;
      pos_ref <= `AHTS_RST_2B;
      internal_src_sel <= 1'b0;
      input_channel_reg <= `AHTS_RST_CHAN;
    end
    else if (wr_ok)
    begin
      if (hit(reg_addr, `AHTS_A_MODE1))
      begin
        trig_src <= reg_wdata[`AHTS_M1_SRC];
        trig_mode <= reg_wdata[`AHTS_M1_TMODE];
        oneshot_sel <= reg_wdata[`AHTS_M1_ONESHOT];
      end
      if (hit(reg_addr, `AHTS_A_MODE2))
      begin
        resolution_sel <= reg_wdata[`AHTS_M2_RES];
        neg_ref_sel <= reg_wdata[`AHTS_M2_NREF];
        pos_ref <= reg_wdata[`AHTS_M2_PREF];
      end
      if (hit(reg_addr, `AHTS_A_CHAN))
      begin
        internal_src_sel <= reg_wdata[`AHTS_CH_ISS];
        input_channel_reg <= reg_wdata[`AHTS_CH_NUM];
      end
    end
  end

  // Active settings applied at enable and at each start from idle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      amux_sel <= `AHTS_RST_CHAN;
      amux_internal <= 1'b0;
      pos_ref_out <= `AHTS_RST_2B;
      neg_ref_out <= 1'b0;
      act_res <= 1'b0;
    end
    else if (load_cfg)
    begin
      amux_sel <= input_channel_reg;
      amux_internal <= internal_src_sel;
      pos_ref_out <= pos_ref;
      neg_ref_out <= neg_ref_sel;
      act_res <= resolution_sel;
    end
  end

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      ahts_pkg::ST_STOP:
        if (conv_enable)
          next_state = ahts_pkg::ST_IDLE;
      ahts_pkg::ST_IDLE:
        if (start_go)
          next_state = ahts_pkg::ST_CONV;
      ahts_pkg::ST_CONV:
        if (!conv_start_arm)
          next_state = ahts_pkg::ST_IDLE;
        else if (tcnt == CNT_W'(CONV_CYCLES - 1))
          next_state = ahts_pkg::ST_STORE;
      ahts_pkg::ST_STORE:
        next_state = ahts_pkg::ST_DONE;
      ahts_pkg::ST_DONE:
        if (!oneshot_sel && conv_start_arm)
          next_state = ahts_pkg::ST_CONV;
        else
          next_state = ahts_pkg::ST_IDLE;
      default:
        next_state = ahts_pkg::ST_STOP;
    endcase
    if (!conv_enable || !conv_clock_gate)
      next_state = ahts_pkg::ST_STOP;
  end

  // State and busy flag
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ahts_pkg::ST_STOP;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      busy <= (next_state == ahts_pkg::ST_CONV) || (next_state == ahts_pkg::ST_STORE);
    end
  end

  // Conversion timing counters
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tcnt <= '0;
      scnt <= '0;
      step <= 4'h0;
    end
    else if (state != ahts_pkg::ST_CONV)
    begin
      tcnt <= '0;
      scnt <= '0;
      step <= 4'h0;
    end
    else
    begin
      tcnt <= tcnt + 1'b1;
      scnt <= tick ? '0 : scnt + 1'b1;
      if (tick && step != 4'(STEPS - 1))
        step <= step + 4'h1;
    end
  end

  // Comparator synchroniser, change taken when stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      comp_s3 <= 1'b0;
      comp_q <= 1'b0;
    end
    else
    begin
      comp_s1 <= comp_in;
      comp_s2 <= comp_s1;
      comp_s3 <= comp_s2;
      if (comp_s2 == comp_s3)
        comp_q <= comp_s3;
    end
  end

  // Sample window and successive approximation
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dac_code <= `AHTS_RST_RES;
      sample_en <= 1'b0;
    end
    else
    begin
      sample_en <= (next_state == ahts_pkg::ST_CONV) &&
                   ((state != ahts_pkg::ST_CONV) ||
                    (step < 4'(`AHTS_SAMPLE_STEPS - 1)) ||
                    ((step == 4'(`AHTS_SAMPLE_STEPS - 1)) && !tick));
      if (state != ahts_pkg::ST_CONV && next_state == ahts_pkg::ST_CONV)
        dac_code <= `AHTS_RST_RES;
      else if (tick && step == 4'(`AHTS_SAMPLE_STEPS - 1))
        dac_code <= `AHTS_SAR_MSB;
      else if (tick && step >= 4'(`AHTS_SAMPLE_STEPS) && bitpos >= lowbit)
      begin
        dac_code[bitpos] <= comp_q;
        if (bitpos > lowbit)
          dac_code[bitpos - 4'h1] <= 1'b1;
      end
    end
  end

  // Result register, written before the request is raised
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      conv_result_reg <= `AHTS_RST_RES;
    else if (state == ahts_pkg::ST_STORE)
      conv_result_reg <= dac_code;
  end

  // Events: conversion end and trigger during conversion
  assign irq_evt[`AHTS_IRQ_DONE] = (state == ahts_pkg::ST_DONE);
  assign irq_evt[`AHTS_IRQ_OVR] = conv_start_arm && hw_mode && trig_sel &&
                                 (state != ahts_pkg::ST_IDLE) &&
                                 (state != ahts_pkg::ST_STOP);

  // Sticky status, set wins over read clear
  for (genvar i = 0; i < 2; i++)
  begin : g_stat
    assign next_stat[i] = (irq_stat[i] && !(rd_ok && hit(reg_addr, `AHTS_A_STAT))) ||
                          irq_evt[i];
  end

  // Status, mask and interrupt outputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_stat <= `AHTS_RST_2B;
      irq_mask <= `AHTS_RST_2B;
      irq <= 1'b0;
      conv_done_irq <= 1'b0;
    end
    else
    begin
      irq_stat <= next_stat;
      if (wr_ok && hit(reg_addr, `AHTS_A_MASK))
        irq_mask <= reg_wdata[1:0];
      irq <= |(next_stat & ((wr_ok && hit(reg_addr, `AHTS_A_MASK)) ?
                            reg_wdata[1:0] : irq_mask));
      conv_done_irq <= irq_evt[`AHTS_IRQ_DONE];
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= `AHTS_RST_DATA;
    else
    begin
      reg_rdata <= `AHTS_RST_DATA;
      if (reg_rd && hit(reg_addr, `AHTS_A_PERIPH))
        reg_rdata[`AHTS_PE_GATE] <= conv_clock_gate;
      else if (rd_ok)
        case (reg_addr)
          `AHTS_A_MODE0: reg_rdata[3:0] <= {busy, chan_sel_mode, conv_start_arm, conv_enable};
          `AHTS_A_MODE1: reg_rdata[4:0] <= {trig_mode, oneshot_sel, trig_src};
          `AHTS_A_MODE2: reg_rdata[3:0] <= {pos_ref, neg_ref_sel, resolution_sel};
          `AHTS_A_CHAN: reg_rdata[7:0] <= {internal_src_sel, 2'h0, input_channel_reg};
          `AHTS_A_RESULT: reg_rdata[11:0] <= conv_result_reg;
          `AHTS_A_STAT: reg_rdata[1:0] <= irq_stat;
          `AHTS_A_MASK: reg_rdata[1:0] <= irq_mask;
          default: reg_rdata <= `AHTS_RST_DATA;
        endcase
    end
  end

  // Helper: cycles spent converting
  logic [CNT_W-1:0] conv_len;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      conv_len <= '0;
    else if (state == ahts_pkg::ST_CONV)
      conv_len <= conv_len + 1'b1;
    else
      conv_len <= '0;
  end

  sequence s_store;
    state == ahts_pkg::ST_STORE;
  endsequence
  sequence s_result_then_irq;
    (conv_result_reg == $past(dac_code) && !conv_done_irq) ##1 conv_done_irq;
  endsequence

  AST_ENABLE_READY: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ahts_pkg::ST_STOP && conv_enable && conv_clock_gate) |=>
    (state == ahts_pkg::ST_IDLE && amux_sel == $past(input_channel_reg)))
    else $error("enable did not reach ready");
  AST_ARM_WAITS: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ahts_pkg::ST_IDLE && hw_mode && !trig_sel) |=> state != ahts_pkg::ST_CONV)
    else $error("conversion began without trigger");
  AST_TRIG_START: assert property (@(posedge ref_clk) disable iff (!nrst)
    (trig_hit && conv_enable && conv_clock_gate) |=>
    (state == ahts_pkg::ST_CONV && busy && amux_sel == $past(input_channel_reg)))
    else $error("armed trigger did not start conversion");
  AST_RESULT_THEN_IRQ: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_store ##1 (conv_enable && conv_clock_gate) |-> s_result_then_irq)
    else $error("result and request out of order");
  AST_STAYS_ARMED: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ahts_pkg::ST_DONE && hw_mode && oneshot_sel && conv_enable &&
     conv_clock_gate && !reg_wr) |=> (conv_start_arm && state == ahts_pkg::ST_IDLE))
    else $error("one-shot did not rearm");
  AST_TIMER_SOURCE: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ahts_pkg::ST_IDLE && conv_start_arm && trig_mode == `AHTS_TM_HW_NOWAIT &&
     trig_src == `AHTS_SRC_TIMER1 && timer_ch1_irq && conv_enable && conv_clock_gate &&
     !reg_wr) |=> state == ahts_pkg::ST_CONV)
    else $error("timer trigger not taken");
  AST_CONV_TIME: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_store |-> conv_len == CNT_W'(CONV_CYCLES))
    else $error("conversion length wrong");
  AST_GATE_READ: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_rd && !conv_clock_gate) |=> reg_rdata == `AHTS_RST_DATA)
    else $error("gated register read nonzero");
  AST_DISABLE_STOP: assert property (@(posedge ref_clk) disable iff (!nrst)
    !conv_enable |=> (state == ahts_pkg::ST_STOP && !busy && !sample_en))
    else $error("disabled converter not stopped");

endmodule // ahts_sequencer

// ### verif/ahts_front_model.sv
// Far-side model: timer channel 1 trigger and amplifier output on the mux.
// Assumes the sequencer's trial code and mux outputs; comparator is ideal.
`timescale 1ns/100ps
module ahts_front_model #(
  parameter int TRIG_PERIOD = 400
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bench control
  input wire logic timer_run,
  input wire logic [11:0] amp_level,
  // Sequencer side
  input wire logic [11:0] dac_code,
  input wire logic [4:0] amux_sel,
  input wire logic amux_internal,
  output logic comp_in,
  output logic timer_ch1_irq
);
  logic [15:0] tcnt;
  logic [11:0] level;
  // One-cycle trigger every period while running
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tcnt <= 16'h0000;
      timer_ch1_irq <= 1'b0;
    end
    else
    begin
      timer_ch1_irq <= timer_run && (tcnt == 16'(TRIG_PERIOD - 1));
      tcnt <= (!timer_run || tcnt == 16'(TRIG_PERIOD - 1)) ? 16'h0000 : tcnt + 16'h0001;
    end
  end
  // Amplifier sits on input 2 only; other inputs see the inverse
  assign level = (amux_sel == 5'h02 && !amux_internal) ? amp_level : ~amp_level;
  // Half a step above its code, so ties never decide a bit
  assign comp_in = {level, 1'b1} > {dac_code, 1'b0};
endmodule // ahts_front_model

// ### verif/testbench.sv
// Self-checking bench for the timer-triggered conversion sequencer.
// Assumes the far-side model for trigger and analog input; short conversion.
`timescale 1ns/100ps
`include "ahts_defs.svh"
module testbench;
  localparam int CONV = 256;
  localparam int PERIOD = 400;
  localparam int LIMIT = 20000;
  localparam int SAMPLE = `AHTS_SAMPLE_STEPS * (CONV / (`AHTS_SAMPLE_STEPS + `AHTS_RES_BITS));
  logic ref_clk, nrst, reg_wr, reg_rd, comp_in, timer_ch1_irq, timer_run;
  logic [2:0] reg_addr, ext_trig;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic [11:0] dac_code, amp_level;
  logic [4:0] amux_sel;
  logic [1:0] pos_ref_out;
  logic sample_en, amux_internal, neg_ref_out, busy, conv_done_irq, irq;
  int n_fail, comparisons, cycles, acc;

  ahts_sequencer #(.CONV_CYCLES(CONV)) DUT (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_ch1_irq(timer_ch1_irq), .ext_trig(ext_trig),
    .comp_in(comp_in), .dac_code(dac_code), .sample_en(sample_en), .amux_sel(amux_sel),
    .amux_internal(amux_internal), .pos_ref_out(pos_ref_out), .neg_ref_out(neg_ref_out),
    .busy(busy), .conv_done_irq(conv_done_irq), .irq(irq));
  ahts_front_model #(.TRIG_PERIOD(PERIOD)) partner (.ref_clk(ref_clk), .nrst(nrst),
    .timer_run(timer_run), .amp_level(amp_level), .dac_code(dac_code),
    .amux_sel(amux_sel), .amux_internal(amux_internal), .comp_in(comp_in),
    .timer_ch1_irq(timer_ch1_irq));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
    check(rd, exp);
  endtask
  // Wait a bounded time for busy or the done pulse
  task automatic wait_high(input bit on_irq, input int max);
    int i;
    for (i = 0; i < max; i++)
    begin
      @(posedge ref_clk);
      #1;
      if ((on_irq ? conv_done_irq : busy) === 1'b1)
        break;
    end
    check({15'h0, (on_irq ? conv_done_irq : busy)}, 16'h0001);
  endtask
  // Count busy cycles over a window where nothing may start
  task automatic watch_idle(input int len);
    int i, n;
    n = 0;
    for (i = 0; i < len; i++)
    begin
      @(posedge ref_clk);
      #1;
      if (busy !== 1'b0)
        n++;
    end
    check(16'(n), 16'h0000);
  endtask
  // One triggered conversion: busy length, done pulse, result
  task automatic do_conv(input logic [11:0] lvl, input logic irq_exp);
    int n, ns;
    amp_level <= lvl;
    wait_high(1'b0, PERIOD + 10);
    n = 1;
    ns = (sample_en === 1'b1) ? 1 : 0;
    while (busy === 1'b1 && n < CONV + 50)
    begin
      @(posedge ref_clk);
      #1;
      if (busy === 1'b1)
        n++;
      if (sample_en === 1'b1)
        ns++;
    end
    check(16'(n), 16'(CONV + 1));
    check(16'(ns), 16'(SAMPLE));
    wait_high(1'b1, 5);
    check({15'h0, irq}, {15'h0, irq_exp});
    reg_read(`AHTS_A_RESULT, {4'h0, lvl});
    acc += rd;
    reg_read(`AHTS_A_STAT, 16'h0001);
  endtask

  task automatic t_gate;
    reg_write(`AHTS_A_MODE0, 16'h0001);
    reg_read(`AHTS_A_MODE0, 16'h0000);
    reg_write(`AHTS_A_PERIPH, 16'h0001);
    reg_read(`AHTS_A_PERIPH, 16'h0001);
    reg_read(`AHTS_A_MODE0, 16'h0000);
    reg_read(`AHTS_A_CHAN, 16'h0000);
    $display("test gate done");
  endtask
  task automatic t_setup;
    reg_write(`AHTS_A_MODE1, 16'h0014);
    reg_write(`AHTS_A_MODE2, 16'h0000);
    reg_write(`AHTS_A_CHAN, 16'h0002);
    reg_write(`AHTS_A_MASK, 16'h0001);
    reg_write(`AHTS_A_MODE0, 16'h0001);
    reg_read(`AHTS_A_MODE1, 16'h0014);
    repeat (3) @(posedge ref_clk);
    #1;
    check({11'h0, amux_sel}, 16'h0002);
    check({15'h0, amux_internal}, 16'h0000);
    check({13'h0, pos_ref_out, neg_ref_out}, 16'h0000);
    $display("test setup done");
  endtask
  task automatic t_arm;
    reg_write(`AHTS_A_MODE0, 16'h0003);
    watch_idle(30);
    $display("test arm done");
  endtask
  task automatic t_first;
    timer_run <= 1'b1;
    do_conv(12'h5a3, 1'b1);
    check({15'h0, irq}, 16'h0000);
    reg_read(`AHTS_A_MODE0, 16'h0003);
    watch_idle(20);
    $display("test first done");
  endtask
  task automatic t_mask;
    reg_write(`AHTS_A_MASK, 16'h0000);
    do_conv(12'h2c7, 1'b0);
    check(16'(acc / 2), 16'h0435);
    $display("test mask done");
  endtask
  task automatic t_source;
    reg_write(`AHTS_A_MODE1, 16'h0015);
    watch_idle(PERIOD + 20);
    @(posedge ref_clk);
    ext_trig <= 3'h1;
    @(posedge ref_clk);
    ext_trig <= 3'h0;
    wait_high(1'b0, 3);
    ext_trig <= 3'h1;
    @(posedge ref_clk);
    ext_trig <= 3'h0;
    wait_high(1'b1, CONV + 10);
    reg_read(`AHTS_A_STAT, 16'h0003);
    reg_write(`AHTS_A_MODE1, 16'h0014);
    $display("test source done");
  endtask
  // Software start, eight-bit resolution, arm dropped after one-shot
  task automatic t_soft;
    reg_write(`AHTS_A_MODE2, 16'h0001);
    reg_write(`AHTS_A_MODE1, 16'h0004);
    reg_write(`AHTS_A_MODE0, 16'h0003);
    wait_high(1'b0, 3);
    wait_high(1'b1, CONV + 10);
    reg_read(`AHTS_A_RESULT, 16'h02c0);
    reg_read(`AHTS_A_MODE0, 16'h0001);
    $display("test soft done");
  endtask
  task automatic t_stop;
    reg_write(`AHTS_A_MODE0, 16'h0000);
    reg_read(`AHTS_A_MODE0, 16'h0000);
    watch_idle(PERIOD + 20);
    $display("test stop done");
  endtask

  task automatic final_report;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    acc = 0;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    ext_trig = 3'h0;
    timer_run = 1'b0;
    amp_level = 12'h000;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_gate();
    t_setup();
    t_arm();
    t_first();
    t_mask();
    t_source();
    t_soft();
    t_stop();
    final_report();
  end
endmodule // testbench
